// ===== shared/npic_pkg.sv
package npic_pkg;
    // Request lines: a higher index outranks a lower one
    localparam int NUM_REQ = 8;
    localparam int IDX_W   = 3;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 4;
    localparam int EVT_W   = 4;

    typedef logic [NUM_REQ-1:0] npic_vec_t;
    typedef logic [IDX_W-1:0]   npic_idx_t;
    typedef logic [DATA_W-1:0]  npic_data_t;
    typedef logic [ADDR_W-1:0]  npic_addr_t;

    // Register offsets
    localparam npic_addr_t ADDR_PEND   = 4'h0;
    localparam npic_addr_t ADDR_PRIO   = 4'h1;
    localparam npic_addr_t ADDR_ACT    = 4'h2;
    localparam npic_addr_t ADDR_CTRL   = 4'h3;
    localparam npic_addr_t ADDR_EVT    = 4'h4;
    localparam npic_addr_t ADDR_MASK   = 4'h5;
    localparam npic_addr_t ADDR_REQ_EN = 4'h6;

    // Field positions
    localparam int CTRL_IE_BIT   = 0;
    localparam int EVT_DISPATCH  = 0;
    localparam int EVT_RTI_DONE  = 1;
    localparam int EVT_NEW_REQ   = 2;
    localparam int EVT_RTI_EMPTY = 3;

    // Reset values
    localparam logic       RST_IE     = 1'b0;
    localparam logic [EVT_W-1:0] RST_MASK = 4'h0;
    localparam npic_vec_t  RST_REQ_EN = 8'hff;

    // Instruction cycle length in reference clocks; the return
    // sequence needs three of them, so this must stay at four or more
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] INSTR_DIV = 3'h4;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CLR,
        SEQ_P2P,
        SEQ_P2A
    } npic_seq_e;
endpackage : npic_pkg

// ===== shared/npic_strobe_if.sv
`timescale 1ns/1ps
interface npic_strobe_if;
    logic tick;
    logic rti_req;
    logic clr_stb;
    logic p2p_stb;
    logic p2a_stb;
    logic rti_done;

    modport seq (
        input  tick,
        input  rti_req,
        output clr_stb,
        output p2p_stb,
        output p2a_stb,
        output rti_done
    );

    modport ctl (
        output tick,
        output rti_req,
        input  clr_stb,
        input  p2p_stb,
        input  p2a_stb,
        input  rti_done
    );
endinterface : npic_strobe_if

// ===== verilog/npic_prio_enc.sv
`timescale 1ns/1ps
module npic_prio_enc
    import npic_pkg::*;
(
    // Flags in
    input  wire npic_pkg::npic_vec_t i_vec,
    // Highest flag out
    output      npic_pkg::npic_vec_t o_onehot,
    output      npic_pkg::npic_idx_t o_idx,
    output logic                     o_any
);
    // Upper index wins, so line four beats line two
    always_comb begin
        o_onehot = '0;
        o_idx    = '0;
        o_any    = 1'b0;
        for (int i = 0; i < NUM_REQ; i++) begin
            if (i_vec[i]) begin
                o_onehot = '0;
                o_onehot[i] = 1'b1;
                o_idx    = npic_idx_t'(i);
                o_any    = 1'b1;
            end
        end
    end
endmodule : npic_prio_enc

// ===== verilog/npic_seq.sv
`timescale 1ns/1ps
module npic_seq
    import npic_pkg::*;
(
    // Clock and reset
    input  wire logic    i_ref_clk,
    input  wire logic    i_reset_n,
    // Strobe group
    npic_strobe_if.seq   sif
);
    npic_seq_e state;
    logic      in_rti;

    // Fixed order clear, load, update; no gate from the enable flag
    // or the core's instruction can shorten or drop the load strobe
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state  <= SEQ_IDLE;
            in_rti <= 1'b0;
        end else begin
            case (state)
                SEQ_IDLE: begin
                    if (sif.tick) begin
                        in_rti <= sif.rti_req;
                        state  <= sif.rti_req ? SEQ_CLR : SEQ_P2P;
                    end
                end
                SEQ_CLR: state <= SEQ_P2P;
                SEQ_P2P: state <= SEQ_P2A;
                SEQ_P2A: begin
                    state  <= SEQ_IDLE;
                    in_rti <= 1'b0;
                end
                default: state <= SEQ_IDLE;
            endcase
        end
    end

    assign sif.clr_stb  = (state == SEQ_CLR);
    assign sif.p2p_stb  = (state == SEQ_P2P);
    assign sif.p2a_stb  = (state == SEQ_P2A);
    // Done three cycles after the tick, inside one instruction slot
    assign sif.rti_done = (state == SEQ_P2A) && in_rti;
endmodule : npic_seq

// ===== verilog/npic_top.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module npic_top
    import npic_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    // Peripheral requests
    input  wire npic_pkg::npic_vec_t  i_req,
    // Core instruction strobes
    input  wire logic                 i_return_from_interrupt,
    input  wire logic                 i_disable_interrupts_instr,
    input  wire logic                 i_enable_interrupts_function,
    // Core vector and status
    output logic                      o_vector_valid,
    output npic_pkg::npic_idx_t       o_vector,
    output logic                      o_rti_done,
    output logic                      o_int_enable,
    // Register port
    input  wire npic_pkg::npic_addr_t i_addr,
    input  wire npic_pkg::npic_data_t i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output npic_pkg::npic_data_t      o_rdata,
    output logic                      o_irq
);
    import npic_pkg::*;

    npic_vec_t        pending;
    npic_vec_t        priority_reg;
    npic_vec_t        active;
    npic_vec_t        req_en;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_mask;
    logic [EVT_W-1:0] next_evt;
    logic [DIV_W-1:0] div_cnt;
    logic             rti_pend;
    logic             race_grant;

    npic_vec_t        req_in;
    npic_vec_t        new_req;
    npic_vec_t        pend_top;
    logic             pend_any;
    npic_idx_t        act_idx;
    logic             act_any;
    npic_idx_t        prio_idx;
    logic             prio_any;
    npic_idx_t        new_idx;
    logic             new_any;
    logic             new_outranks;
    npic_data_t       ctrl_word;
    logic             outranks;
    logic             may_dispatch;
    logic             dispatch;
    logic             rd_evt;

    npic_strobe_if sif ();

    // Strobe sequencer
    npic_seq u_seq (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .sif       (sif)
    );

    // Decoders on pending, active and the priority register itself
    npic_prio_enc u_pend_enc (
        .i_vec    (pending),
        .o_onehot (pend_top),
        .o_idx    (),
        .o_any    (pend_any)
    );

    npic_prio_enc u_act_enc (
        .i_vec    (active),
        .o_onehot (),
        .o_idx    (act_idx),
        .o_any    (act_any)
    );

    npic_prio_enc u_prio_enc (
        .i_vec    (priority_reg),
        .o_onehot (),
        .o_idx    (prio_idx),
        .o_any    (prio_any)
    );

    // Top of the lines that latch in this very cycle
    npic_prio_enc u_new_enc (
        .i_vec    (new_req),
        .o_onehot (),
        .o_idx    (new_idx),
        .o_any    (new_any)
    );

    // Instruction cycle divider
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_cnt <= '0;
        end else if (div_cnt == INSTR_DIV - 3'h1) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    // The sequencer is idle again before the next tick can arrive
    assign sif.tick    = (div_cnt == INSTR_DIV - 3'h1);
    assign sif.rti_req = rti_pend;

    // Return request waits for the next instruction slot
    // Only one may be outstanding; the core waits for done
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rti_pend <= 1'b0;
        end else if (i_return_from_interrupt) begin
            rti_pend <= 1'b1;
        end else if (sif.tick) begin
            rti_pend <= 1'b0;
        end
    end

    assign req_in  = i_req & req_en;
    assign new_req = req_in & ~pending;
    assign new_outranks = new_any && (!act_any || (new_idx > act_idx));

    // Pending: set wins over the clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pending <= '0;
        end else if (sif.clr_stb) begin
            pending <= (pending & ~priority_reg) | req_in;
        end else begin
            pending <= pending | req_in;
        end
    end

    // Priority register: one-hot of the top pending flag
    // Limitation: the idle reload runs with interrupts off too, so a
    // return then clears the top pending line even if it never went active
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            priority_reg <= '0;
        end else if (sif.p2p_stb) begin
            priority_reg <= pend_top;
        end
    end

    // Strict outranking keeps equal and lower levels locked out
    assign outranks     = prio_any && (!act_any || (prio_idx > act_idx));
    assign may_dispatch = o_int_enable || race_grant;
    assign dispatch     = sif.p2a_stb && outranks && may_dispatch;

    // Active: clear only the marked bit, add only on outranking
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            active <= '0;
        end else if (sif.clr_stb) begin
            active <= active & ~priority_reg;
        end else if (dispatch) begin
            active <= active | priority_reg;
        end
    end

    // A request that meets the disable keeps its right to vector, but
    // only one that outranks the running routine; a lower one would
    // otherwise slip in later while interrupts are still off
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            race_grant <= 1'b0;
        end else if (i_disable_interrupts_instr && o_int_enable && new_outranks) begin
            race_grant <= 1'b1;
        end else if (dispatch || !pend_any) begin
            race_grant <= 1'b0;
        end
    end

    // Global enable: the return sequence has no path into it
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_int_enable <= RST_IE;
        end else if (i_disable_interrupts_instr) begin
            o_int_enable <= 1'b0;
        end else if (i_enable_interrupts_function) begin
            o_int_enable <= 1'b1;
        end else if (i_wr && (i_addr == ADDR_CTRL)) begin
            o_int_enable <= i_wdata[CTRL_IE_BIT];
        end
    end

    // Vector to the core
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_vector_valid <= 1'b0;
            o_vector       <= '0;
        end else begin
            o_vector_valid <= dispatch;
            if (dispatch) begin
                o_vector <= prio_idx;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rti_done <= 1'b0;
        end else begin
            o_rti_done <= sif.rti_done;
        end
    end

    // Software registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            evt_mask <= RST_MASK;
        end else if (i_wr && (i_addr == ADDR_MASK)) begin
            evt_mask <= i_wdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_en <= RST_REQ_EN;
        end else if (i_wr && (i_addr == ADDR_REQ_EN)) begin
            req_en <= i_wdata;
        end
    end

    // Event flags: a read clears, a coinciding event still sets
    assign rd_evt = i_rd && (i_addr == ADDR_EVT);

    always_comb begin
        next_evt = rd_evt ? '0 : evt;
        if (dispatch) begin
            next_evt[EVT_DISPATCH] = 1'b1;
        end
        if (sif.rti_done) begin
            next_evt[EVT_RTI_DONE] = 1'b1;
        end
        if (new_req != '0) begin
            next_evt[EVT_NEW_REQ] = 1'b1;
        end
        if (sif.clr_stb && !prio_any) begin
            next_evt[EVT_RTI_EMPTY] = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            evt <= '0;
        end else begin
            evt <= next_evt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_evt & evt_mask);
        end
    end

    // Control word assembled from its field positions
    always_comb begin
        ctrl_word              = '0;
        ctrl_word[CTRL_IE_BIT] = o_int_enable;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_PEND:   o_rdata <= pending;
                ADDR_PRIO:   o_rdata <= priority_reg;
                ADDR_ACT:    o_rdata <= active;
                ADDR_CTRL:   o_rdata <= ctrl_word;
                ADDR_EVT:    o_rdata <= {4'h0, evt};
                ADDR_MASK:   o_rdata <= {4'h0, evt_mask};
                ADDR_REQ_EN: o_rdata <= req_en;
                default:     o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end
endmodule : npic_top

// ===== sim/npic_chk.sv
`timescale 1ns/1ps
module npic_chk
    import npic_pkg::*;
(
    // Clock, reset and core strobes
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_return_from_interrupt,
    input  wire logic                 i_disable_interrupts_instr,
    input  wire logic                 i_enable_interrupts_function,
    // Controller outputs and register port
    input  wire logic                 o_vector_valid,
    input  wire npic_pkg::npic_idx_t  o_vector,
    input  wire logic                 o_rti_done,
    input  wire logic                 o_int_enable,
    input  wire npic_pkg::npic_addr_t i_addr,
    input  wire npic_pkg::npic_data_t i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire npic_pkg::npic_data_t o_rdata,
    input  wire logic                 o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    // Enable may lag its strobe by a register, so two quiet cycles are needed
    logic quiet;
    assign quiet = !i_wr && !i_enable_interrupts_function && !i_disable_interrupts_instr;

    a_rti_done_bound: assert property (i_return_from_interrupt |-> ##[5:8] o_rti_done)
        else $error("return sequence did not finish in time");
    a_rti_done_pulse: assert property (o_rti_done |=> !o_rti_done)
        else $error("return done longer than one cycle");
    a_rti_keeps_ie: assert property (i_return_from_interrupt && quiet && $past(quiet) |=> $stable(o_int_enable))
        else $error("return changed the interrupt enable");
    a_dis_drops_ie: assert property (i_disable_interrupts_instr |-> ##[1:2] !o_int_enable)
        else $error("disable did not clear the enable");
    a_en_sets_ie: assert property (i_enable_interrupts_function && !i_disable_interrupts_instr |-> ##[1:2] o_int_enable)
        else $error("enable did not set the enable");
    a_vector_needs_valid: assert property ($changed(o_vector) |-> o_vector_valid)
        else $error("vector moved without a dispatch");
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_rd_unmapped: assert property (i_rd && i_addr > ADDR_REQ_EN |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_mask_off: assert property (i_wr && i_addr == ADDR_MASK && i_wdata[3:0] == 4'h0 |-> ##[1:2] !o_irq)
        else $error("interrupt high with mask cleared");

    c_dispatch: cover property (o_vector_valid);
    c_return: cover property (o_rti_done);
    c_irq: cover property (o_irq);
endmodule : npic_chk

bind npic_top npic_chk npic_chk_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_return_from_interrupt(i_return_from_interrupt), .i_disable_interrupts_instr(i_disable_interrupts_instr),
    .i_enable_interrupts_function(i_enable_interrupts_function), .o_vector_valid(o_vector_valid),
    .o_vector(o_vector), .o_rti_done(o_rti_done), .o_int_enable(o_int_enable), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));

// ===== sim/npic_core_model.sv
`timescale 1ns/1ps
module npic_core_model (
    // Clock
    input  wire logic i_ref_clk,
    // Instruction strobes
    output logic      o_rti,
    output logic      o_di,
    output logic      o_ei,
    // Return completion
    input  wire logic i_rti_done
);
    initial begin
        o_rti = 1'b0;
        o_di = 1'b0;
        o_ei = 1'b0;
    end

    // Called just after a rising edge; sel is {return, disable, enable}
    task automatic issue(input logic [2:0] sel, output logic ok);
        {o_rti, o_di, o_ei} <= sel;
        @(posedge i_ref_clk);
        {o_rti, o_di, o_ei} <= 3'h0;
        ok = 1'b1;
        if (sel[2]) begin
            // A return is not followed by another until it has finished
            ok = 1'b0;
            repeat (12) begin
                @(posedge i_ref_clk);
                #1;
                if (i_rti_done === 1'b1) ok = 1'b1;
            end
        end
    endtask : issue
endmodule : npic_core_model

// ===== sim/test_nested_priority_interrupt_ctrl.sv
`timescale 1ns/1ps
module test_nested_priority_interrupt_ctrl;
    import npic_pkg::*;
    logic       clk     = 1'b0;
    logic       rst_n   = 1'b0;
    npic_vec_t  req     = 8'h00;
    npic_addr_t addr    = 4'h0;
    npic_data_t wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic       return_from_interrupt, di, ei, vv, done, ie, irq, ok;
    npic_idx_t  vec;
    npic_data_t rdata, h;
    int         errors  = 0;
    int         n_tests = 0;

    always #20 clk = ~clk;

    npic_top npic_top_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_return_from_interrupt(return_from_interrupt),
        .i_disable_interrupts_instr(di), .i_enable_interrupts_function(ei), .o_vector_valid(vv), .o_vector(vec),
        .o_rti_done(done), .o_int_enable(ie), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_irq(irq));
    npic_core_model npic_core_model_inst (.i_ref_clk(clk), .o_rti(return_from_interrupt), .o_di(di), .o_ei(ei), .i_rti_done(done));

    task automatic chk(input npic_data_t seen, input npic_data_t exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input npic_addr_t a, input npic_data_t exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic wr_reg(input npic_addr_t a, input npic_data_t d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Counts dispatch pulses over a span of cycles
    task automatic watch(input int n);
        h = 8'h00;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (vv === 1'b1) h++;
        end
    endtask : watch

    task automatic req_pulse(input npic_vec_t v);
        @(posedge clk);
        req <= v;
        @(posedge clk);
        req <= 8'h00;
    endtask : req_pulse

    task automatic t_reset();
        rd_chk(ADDR_PEND, 8'h00);
        rd_chk(ADDR_ACT, 8'h00);
        rd_chk(ADDR_REQ_EN, 8'hff);
        rd_chk(4'hf, 8'h00);
    endtask : t_reset

    task automatic t_first();
        @(posedge clk);
        npic_core_model_inst.issue(3'h1, ok);
        req_pulse(8'h04);
        watch(12);
        chk(h, 8'h01);
        chk(vec, 8'h02);
        rd_chk(ADDR_ACT, 8'h04);
        rd_chk(ADDR_PEND, 8'h04);
    endtask : t_first

    task automatic t_lower();
        req_pulse(8'h02);
        watch(12);
        chk(h, 8'h00);
        rd_chk(ADDR_PEND, 8'h06);
        rd_chk(ADDR_ACT, 8'h04);
    endtask : t_lower

    task automatic t_race();
        @(posedge clk);
        req <= 8'h10;
        npic_core_model_inst.issue(3'h2, ok);
        req <= 8'h00;
        watch(12);
        chk(h, 8'h01);
        chk(vec, 8'h04);
        rd_chk(ADDR_ACT, 8'h14);
        rd_chk(ADDR_PRIO, 8'h10);
        rd_chk(ADDR_CTRL, 8'h00);
        chk(ie, 8'h00);
    endtask : t_race

    // Interrupts are off after the race, the case where the reload used to vanish
    task automatic t_nested_ret();
        @(posedge clk);
        npic_core_model_inst.issue(3'h4, ok);
        chk(ok, 8'h01);
        rd_chk(ADDR_PEND, 8'h06);
        rd_chk(ADDR_ACT, 8'h04);
        rd_chk(ADDR_PRIO, 8'h04);
        rd_chk(ADDR_CTRL, 8'h00);
        chk(ie, 8'h00);
    endtask : t_nested_ret

    task automatic t_last_ret();
        @(posedge clk);
        npic_core_model_inst.issue(3'h4, ok);
        chk(ok, 8'h01);
        rd_chk(ADDR_ACT, 8'h00);
        rd_chk(ADDR_PRIO, 8'h02);
        @(posedge clk);
        npic_core_model_inst.issue(3'h1, ok);
        watch(12);
        chk(h, 8'h01);
        chk(vec, 8'h01);
    endtask : t_last_ret

    task automatic t_irq();
        wr_reg(ADDR_MASK, 8'h02);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, 8'h01);
        rd_chk(ADDR_EVT, 8'h07);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, 8'h00);
        wr_reg(ADDR_MASK, 8'h00);
    endtask : t_irq

    // A return with nothing marked clears nothing; gated lines never latch
    task automatic t_empty_ret();
        @(posedge clk);
        npic_core_model_inst.issue(3'h4, ok);
        chk(ok, 8'h01);
        @(posedge clk);
        npic_core_model_inst.issue(3'h4, ok);
        chk(ok, 8'h01);
        rd_chk(ADDR_EVT, 8'h0a);
        rd_chk(ADDR_ACT, 8'h00);
        rd_chk(ADDR_PEND, 8'h00);
        wr_reg(ADDR_REQ_EN, 8'hf7);
        req_pulse(8'h08);
        rd_chk(ADDR_PEND, 8'h00);
        wr_reg(ADDR_REQ_EN, 8'hff);
    endtask : t_empty_ret

    // Software enable, then a lower line meeting the disable gets no grant
    task automatic t_ctrl();
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h00);
        chk(ie, 8'h00);
        req_pulse(8'h08);
        watch(12);
        chk(h, 8'h00);
        wr_reg(ADDR_CTRL, 8'h01);
        watch(12);
        chk(h, 8'h01);
        chk(vec, 8'h03);
        chk(ie, 8'h01);
        @(posedge clk);
        req <= 8'h02;
        npic_core_model_inst.issue(3'h2, ok);
        req <= 8'h00;
        watch(12);
        chk(h, 8'h00);
        @(posedge clk);
        npic_core_model_inst.issue(3'h4, ok);
        chk(ok, 8'h01);
        rd_chk(ADDR_ACT, 8'h00);
        rd_chk(ADDR_PRIO, 8'h02);
        rd_chk(ADDR_PEND, 8'h02);
        chk(ie, 8'h00);
    endtask : t_ctrl

    task automatic wrap_up();
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_first();
        t_lower();
        t_race();
        t_nested_ret();
        t_last_ret();
        t_irq();
        t_empty_ret();
        t_ctrl();
        wrap_up();
    end

    initial begin
        #(40 * 2000);
        errors++;
        wrap_up();
    end
endmodule : test_nested_priority_interrupt_ctrl
